//--- rtl/usbep_ctrl.sv
// How it works
// - sixteen endpoint control words, endpoints 0 to 15
// - endpoint zero bit 7 enables low-speed direct
// - endpoint zero bit 6 set stops NAK retries
// - bit 6 clear lets hardware retry NAKs
// - bits 7 and 6 exist only ep0, host
// - elsewhere bits 7 and 6 read zero
// - tx, rx and bit 4 set refuse SETUP
// - tx, rx and bit 4 clear accept SETUP
// - bit 4 ignored unless tx and rx set
// - receive allowed only with receive enable
// - transmit allowed only with transmit enable
// - stall bit set when endpoint stalled
// - handshake bit set enables handshakes
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
module usbep_ctrl
  import usbep_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tok_valid,
  input wire logic [3:0] tok_ep,
  input wire logic [1:0] tok_kind,
  input wire logic tok_stall,
  input wire logic tok_nak,
  output logic tok_accept,
  output logic tok_refuse,
  output logic tok_handshake,
  output logic tok_retry,
  output logic low_speed_direct_en,
  output logic irq
);

  // state type for the write channel pairing
  typedef enum logic [2:0] {
    W_IDLE = 3'b001,
    W_RESP = 3'b010,
    W_HOLD = 3'b100
  } usbep_wst_t;

  // endpoint storage and control state
  logic [15:0] ep_q [EP_COUNT];          // endpoint control words
  logic [15:0] ep_d [EP_COUNT];
  logic host_mode_q, host_mode_d;        // host mode select
  logic [1:0] ists_q, ists_d;            // sticky interrupt status
  logic [1:0] imask_q, imask_d;          // interrupt mask
  usbep_wst_t wst_q, wst_d;              // write channel state
  logic aw_got_q, aw_got_d;              // write address held
  logic w_got_q, w_got_d;                // write data held
  logic [7:0] awaddr_q, awaddr_d;
  logic [15:0] wdata_q, wdata_d;
  logic [1:0] wstrb_q, wstrb_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic acc_q, acc_d, ref_q, ref_d, hs_q, hs_d, rty_q, rty_d;
  logic irq_q, irq_d;
  logic lsd_q, lsd_d;  // low-speed direct level
  logic [2:0] rdy_q, rdy_d;  // aw, w and ar ready flops

  // writable bits of one endpoint word
  function automatic logic [15:0] ep_mask(input logic [3:0] n, input logic host);
    ep_mask = (n == 4'h0 && host) ? EP0_HOST_MASK : EP_PLAIN_MASK;
  endfunction

  // decode of an endpoint word address
  function automatic logic is_ep(input logic [7:0] a);
    is_ep = (a[7:6] == EP_BASE_ADDR[7:6]) && (a[1:0] == 2'h0);
  endfunction

  // is the address one of the mapped words
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = is_ep(a) || a == INT_STATUS_ADDR || a == INT_MASK_ADDR
      || a == MODE_ADDR;
  endfunction

  // readback value of one address
  function automatic logic [31:0] rd_value(input logic [7:0] a);
    logic [3:0] n;
    n = a[5:2];
    rd_value = 32'h0000_0000;
    if (is_ep(a))
    begin
      rd_value = {16'h0000, ep_q[n] & ep_mask(n, host_mode_q)};
    end
    else if (a == INT_STATUS_ADDR)
    begin
      rd_value = {30'h0, ists_q};
    end
    else if (a == INT_MASK_ADDR)
    begin
      rd_value = {30'h0, imask_q};
    end
    else if (a == MODE_ADDR)
    begin
      rd_value = {31'h0, host_mode_q};
    end
  endfunction

  // next-state logic for registers, bus and link answers
  always_comb
  begin
    logic [15:0] cur;
    logic [15:0] m;
    logic [15:0] wbits;
    logic [3:0] wn;
    logic bidir;
    logic wr_fire;
    cur = 16'h0000;
    m = 16'h0000;
    wn = awaddr_q[5:2];
    wbits = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    bidir = 1'b0;
    for (int i = 0; i < EP_COUNT; i++)
    begin
      ep_d[i] = ep_q[i];
    end
    host_mode_d = host_mode_q;
    ists_d = ists_q;
    imask_d = imask_q;
    wst_d = wst_q;
    aw_got_d = aw_got_q;
    w_got_d = w_got_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    acc_d = 1'b0;
    ref_d = 1'b0;
    hs_d = 1'b0;
    rty_d = 1'b0;
    wr_fire = 1'b0;
    // write channel: take address and data in either order
    case (wst_q)
      W_IDLE:
      begin
        if (s_axi_awvalid && !aw_got_q)
        begin
          aw_got_d = 1'b1;
          awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_got_q)
        begin
          w_got_d = 1'b1;
          wdata_d = s_axi_wdata[15:0];
          wstrb_d = s_axi_wstrb[1:0];
        end
        if (aw_got_q && w_got_q)
        begin
          wst_d = W_RESP;
        end
      end
      W_RESP:
      begin
        // perform the write one cycle before the response
        wr_fire = 1'b1;
        bresp_d = is_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
        wst_d = W_HOLD;
      end
      W_HOLD:
      begin
        if (s_axi_bready)
        begin
          wst_d = W_IDLE;
          aw_got_d = 1'b0;
          w_got_d = 1'b0;
        end
      end
      default:
      begin
        wst_d = W_IDLE;
      end
    endcase
    // link events: stall marking and token verdicts
    if (tok_valid)
    begin
      cur = ep_q[tok_ep] & ep_mask(tok_ep, host_mode_q);
      bidir = cur[TX_EN_BIT] && cur[RX_EN_BIT];
      if (tok_stall)
      begin
        ep_d[tok_ep][STALL_BIT] = 1'b1;
        ists_d[IRQ_STALL_BIT] = 1'b1;
      end
      case (tok_kind)
        TOK_SETUP: acc_d = bidir && !cur[CON_DIS_BIT];
        TOK_OUT: acc_d = cur[RX_EN_BIT];
        TOK_IN: acc_d = cur[TX_EN_BIT];
        default: acc_d = 1'b0;
      endcase
      ref_d = !acc_d;
      hs_d = acc_d && cur[HSHK_BIT];
      // ep0 host-only retry control; set bit stops retries
      rty_d = tok_nak && !(tok_ep == 4'h0 && cur[RETRY_DIS_BIT]);
      if (!acc_d)
      begin
        ists_d[IRQ_REFUSE_BIT] = 1'b1;
      end
    end
    // register write; hardware set wins over clear, except on a status bit that was already set
    if (wr_fire)
    begin
      if (is_ep(awaddr_q))
      begin
        m = ep_mask(wn, host_mode_q) & wbits;
        ep_d[wn] = (ep_q[wn] & ~m) | (wdata_q & m);
        if (tok_valid && tok_stall && tok_ep == wn)
        begin
          ep_d[wn][STALL_BIT] = 1'b1;
        end
      end
      else if (awaddr_q == INT_STATUS_ADDR && wstrb_q[0])
      begin
        ists_d = ists_d & ~(wdata_q[1:0] & ~(ists_d ^ ists_q))
          | (ists_d & ~ists_q);
      end
      else if (awaddr_q == INT_MASK_ADDR && wstrb_q[0])
      begin
        imask_d = wdata_q[1:0];
      end
      else if (awaddr_q == MODE_ADDR && wstrb_q[0])
      begin
        host_mode_d = wdata_q[0];
      end
    end
    // read channel: one cycle from address to data
    if (rvalid_q)
    begin
      if (s_axi_rready)
      begin
        rvalid_d = 1'b0;
      end
    end
    else if (s_axi_arvalid)
    begin
      rvalid_d = 1'b1;
      rdata_d = rd_value(s_axi_araddr);
      rresp_d = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    irq_d = |(ists_d & imask_d);
    lsd_d = host_mode_q && ep_q[0][LOW_SPEED_DIRECT_EN_BIT];
    rdy_d = {wst_d == W_IDLE && !aw_got_d, wst_d == W_IDLE && !w_got_d, !rvalid_d};
  end

  // registered state, synchronous active-low reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < EP_COUNT; i++)
      begin
        ep_q[i] <= EP_RESET;
      end
      host_mode_q <= 1'b0;
      ists_q <= IRQ_RESET;
      imask_q <= IRQ_RESET;
      wst_q <= W_IDLE;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 16'h0000;
      wstrb_q <= 2'h0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
      acc_q <= 1'b0;
      ref_q <= 1'b0;
      hs_q <= 1'b0;
      rty_q <= 1'b0;
      irq_q <= 1'b0;
      lsd_q <= 1'b0;
      rdy_q <= 3'h7;
    end
    else
    begin
      for (int i = 0; i < EP_COUNT; i++)
      begin
        ep_q[i] <= ep_d[i];
      end
      host_mode_q <= host_mode_d;
      ists_q <= ists_d;
      imask_q <= imask_d;
      wst_q <= wst_d;
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      acc_q <= acc_d;
      ref_q <= ref_d;
      hs_q <= hs_d;
      rty_q <= rty_d;
      irq_q <= irq_d;
      lsd_q <= lsd_d;
      rdy_q <= rdy_d;
    end
  end

  // outputs straight from flops
  assign s_axi_awready = rdy_q[2];
  assign s_axi_wready = rdy_q[1];
  assign s_axi_bvalid = wst_q[2];
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = rdy_q[0];
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign tok_accept = acc_q;
  assign tok_refuse = ref_q;
  assign tok_handshake = hs_q;
  assign tok_retry = rty_q;
  assign low_speed_direct_en = lsd_q;
  assign irq = irq_q;

endmodule

//--- rtl/usbep_pkg.sv
package usbep_pkg;
  // register map: sixteen endpoint words, then interrupt status, mask and mode
  localparam int unsigned EP_COUNT = 16;
  localparam logic [7:0] EP_BASE_ADDR = 8'h00;     // endpoint n at 4*n
  localparam logic [7:0] INT_STATUS_ADDR = 8'h40;  // sticky event bits
  localparam logic [7:0] INT_MASK_ADDR = 8'h44;    // interrupt enables
  localparam logic [7:0] MODE_ADDR = 8'h48;        // host mode select
  // endpoint control field positions
  localparam int unsigned LOW_SPEED_DIRECT_EN_BIT = 7;
  localparam int unsigned RETRY_DIS_BIT = 6;
  localparam int unsigned CON_DIS_BIT = 4;
  localparam int unsigned RX_EN_BIT = 3;
  localparam int unsigned TX_EN_BIT = 2;
  localparam int unsigned STALL_BIT = 1;
  localparam int unsigned HSHK_BIT = 0;
  // writable masks: endpoint zero in host mode, and every other case
  localparam logic [15:0] EP0_HOST_MASK = 16'h00df;
  localparam logic [15:0] EP_PLAIN_MASK = 16'h001f;
  localparam logic [15:0] EP_RESET = 16'h0000;
  // interrupt status bits
  localparam int unsigned IRQ_STALL_BIT = 0;
  localparam int unsigned IRQ_REFUSE_BIT = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // transaction kinds seen from the link engine
  localparam logic [1:0] TOK_OUT = 2'h0;
  localparam logic [1:0] TOK_IN = 2'h1;
  localparam logic [1:0] TOK_SETUP = 2'h2;
endpackage

//--- test/usbep_ctrl_properties.sv
module usbep_ctrl_props
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tok_valid,
  input wire logic [3:0] tok_ep,
  input wire logic tok_nak,
  input wire logic tok_accept,
  input wire logic tok_refuse,
  input wire logic tok_handshake,
  input wire logic tok_retry,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // address and data taken at one edge
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // a token and the cycle that answers it
  sequence tok_seen;
    tok_valid ##1 1'b1;
  endsequence
  wr_answer_a:
    assert property (wr_taken |-> ##[1:4] s_axi_bvalid)
    else $error("write answer late");
  rd_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  b_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  r_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped");
  tok_answer_a:
    assert property (tok_seen |-> tok_accept != tok_refuse)
    else $error("token answer not exclusive");
  tok_quiet_a:
    assert property (!tok_valid |=> !tok_accept && !tok_refuse)
    else $error("answer without token");
  hshk_accept_a:
    assert property (tok_handshake |-> tok_accept)
    else $error("handshake on refused token");
  retry_cause_a:
    assert property (tok_retry |-> $past(tok_valid) && $past(tok_nak))
    else $error("retry without nak");
  retry_plain_a:
    assert property (tok_valid && tok_nak && tok_ep != 4'h0 |=> tok_retry)
    else $error("nak not retried");
  irq_reset_a:
    assert property ($rose(aresetn) |-> !irq)
    else $error("irq high after reset");
endmodule

bind usbep_ctrl usbep_ctrl_props u_props (.*);

//--- test/usbep_engine_model.sv
module usbep_engine_model
(
  input wire logic aclk,
  output logic tok_valid,
  output logic [3:0] tok_ep,
  output logic [1:0] tok_kind,
  output logic tok_stall,
  output logic tok_nak,
  input wire logic tok_accept,
  input wire logic tok_refuse,
  input wire logic tok_handshake,
  input wire logic tok_retry
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle link engine at time zero
  initial
  begin
    tok_valid = 1'b0;
    {tok_ep, tok_kind, tok_stall, tok_nak} = 8'h00;
  end
  // one token, answer taken the cycle after; qualifiers scrambled after
  task automatic send(input logic [3:0] ep, input logic [1:0] kd, input logic st,
                      input logic nk, output logic [3:0] ans);
    @(posedge aclk);
    tok_valid <= 1'b1;
    {tok_ep, tok_kind, tok_stall, tok_nak} <= {ep, kd, st, nk};
    @(posedge aclk);
    tok_valid <= 1'b0;
    {tok_ep, tok_kind, tok_stall, tok_nak} <= ~{ep, kd, st, nk};
    @(posedge aclk);
    ans = {tok_accept, tok_refuse, tok_handshake, tok_retry};
  endtask
endmodule

//--- test/usbep_ctrl_tb.sv
module usbep_ctrl_tb
  import usbep_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, tok_valid, tok_stall, tok_nak, tok_accept, tok_refuse;
  logic tok_handshake, tok_retry, low_speed_direct_en, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, tok_ep, ans;
  logic [1:0] s_axi_bresp, s_axi_rresp, tok_kind, rs;
  int errors, comparisons;
  usbep_ctrl dut (.*);
  usbep_engine_model eng (.*);
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // write: both channels offered, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    {rd, rs} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
    chk(rd, exp);
  endtask
  // reset values of every endpoint word, unmapped address refused
  task automatic t_reset();
    for (int i = 0; i < 16; i++)
      rchk(8'(4 * i), 32'h0);
    rchk(8'h4c, 32'h0);
    chk(32'(rs), 32'(RESP_SLVERR));
    wr(8'h4c, 32'h1);
    chk(32'(rs), 32'(RESP_SLVERR));
  endtask
  // writable bits per endpoint and mode
  task automatic t_bits();
    for (int i = 0; i < 16; i++)
      wr(8'(4 * i), 32'hffffffff);
    for (int i = 0; i < 16; i++)
      rchk(8'(4 * i), 32'h1f);
    wr(MODE_ADDR, 32'h1);
    chk(32'(rs), 32'(RESP_OKAY));
    rchk(MODE_ADDR, 32'h1);
    wr(EP_BASE_ADDR, 32'hff);
    rchk(EP_BASE_ADDR, 32'hdf);
    rchk(8'h14, 32'h1f);
    chk(32'(low_speed_direct_en), 32'h1);
    wr(MODE_ADDR, 32'h0);
    rchk(EP_BASE_ADDR, 32'h1f);
    chk(32'(low_speed_direct_en), 32'h0);
  endtask
  // every enable combination against every token kind
  task automatic t_dirs();
    logic [4:0] c;
    logic a;
    for (int v = 0; v < 16; v++)
    begin
      c = {v[3], v[2], v[1], 1'b0, v[0]};
      wr(8'h0c, 32'(c));
      for (int k = 0; k < 4; k++)
      begin
        eng.send(4'h3, 2'(k), 1'b0, 1'b0, ans);
        a = (k == 0) ? c[3] : (k == 1) ? c[2] : (k == 2) ? (c[3] & c[2] & !c[4]) : 1'b0;
        chk(32'(ans), 32'({a, !a, a & c[0], 1'b0}));
      end
    end
  endtask
  // nak retry on endpoint zero, host and device mode
  task automatic t_retry();
    wr(MODE_ADDR, 32'h1);
    wr(EP_BASE_ADDR, 32'h4c);
    eng.send(4'h0, TOK_OUT, 1'b0, 1'b1, ans);
    chk(32'(ans[0]), 32'h0);
    eng.send(4'h5, TOK_OUT, 1'b0, 1'b1, ans);
    chk(32'(ans[0]), 32'h1);
    wr(EP_BASE_ADDR, 32'h0c);
    eng.send(4'h0, TOK_IN, 1'b0, 1'b1, ans);
    chk(32'(ans[0]), 32'h1);
    wr(MODE_ADDR, 32'h0);
    wr(EP_BASE_ADDR, 32'h4c);
    eng.send(4'h0, TOK_OUT, 1'b0, 1'b1, ans);
    chk(32'(ans[0]), 32'h1);
  endtask
  // stall flag, refusal event, mask and clear of the interrupt
  task automatic t_stall();
    wr(INT_STATUS_ADDR, 32'h3);
    wr(8'h10, 32'h0);
    wr(8'h08, 32'h1d);
    eng.send(4'h2, TOK_OUT, 1'b1, 1'b0, ans);
    rchk(8'h08, 32'h1f);
    eng.send(4'h4, TOK_IN, 1'b0, 1'b0, ans);
    rchk(INT_STATUS_ADDR, 32'h3);
    chk(32'(irq), 32'h0);
    wr(INT_MASK_ADDR, 32'h2);
    rchk(INT_MASK_ADDR, 32'h2);
    rchk(INT_STATUS_ADDR, 32'h3);
    chk(32'(irq), 32'h1);
    wr(INT_STATUS_ADDR, 32'h2);
    rchk(INT_STATUS_ADDR, 32'h1);
    chk(32'(irq), 32'h0);
  endtask
  initial
  begin
    #200000;
    errors++;
    report_and_stop();
  end
  initial
  begin
    {errors, comparisons} = '0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
    {s_axi_wdata, s_axi_wstrb} = 36'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_bits();
    t_dirs();
    t_retry();
    t_stall();
    report_and_stop();
  end
endmodule
